// file: include/gpf_params.svh
// gpf_params.svh - constants of the general-purpose fuse controller:
// register offsets, field positions, command codes, fuse numbers.
// assumes a 32-bit classic wishbone slave with byte addresses.
`ifndef GPF_PARAMS_SVH
`define GPF_PARAMS_SVH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define GPF_ADR_W 8
`define GPF_ADR_CMD 8'h04
`define GPF_ADR_STAT 8'h08
`define GPF_ADR_FHI 8'h14
`define GPF_ADR_FLO 8'h18

// ----------------------------------------------------------------------
// command register fields
// ----------------------------------------------------------------------
`define GPF_KEY 8'ha5
`define GPF_KEY_LSB 24
`define GPF_PAGE_LSB 8
`define GPF_PAGE_W 16
`define GPF_CMD_W 6
`define GPF_BYTE_W 3
`define GPF_VAL_LSB 3

// command codes
`define GPF_C_NOP 6'h00
`define GPF_C_WP 6'h01
`define GPF_C_EP 6'h02
`define GPF_C_LP 6'h04
`define GPF_C_UP 6'h05
`define GPF_C_WBIT 6'h07
`define GPF_C_EBIT 6'h08
`define GPF_C_PBYTE 6'h0b
`define GPF_C_EALL 6'h0c

// ----------------------------------------------------------------------
// status register bits
// ----------------------------------------------------------------------
`define GPF_ST_RDY 0
`define GPF_ST_LOCK_ERR 2
`define GPF_ST_PROG_ERR 3
`define GPF_ST_SEC 4
`define GPF_ST_LOCK_LSB 16

// ----------------------------------------------------------------------
// special fuse numbers
// ----------------------------------------------------------------------
`define GPF_N_LOCK 16
`define GPF_F_FETCH_LOCK 16
`define GPF_F_BP_LO 17
`define GPF_F_BP_HI 19
`define GPF_F_SEC_LO 20
`define GPF_F_SEC_HI 21
`define GPF_F_USER_PROT 22
`define GPF_BYTE_SEC 3'h2
`define GPF_BP_NONE 3'h7
`define GPF_BP_MAXLOG 3'h7

// busy time of one fuse operation in clk cycles
`define GPF_OP_CYCLES 4
`define GPF_PAGES 256

`endif

// file: include/gpf_pkg.sv
// gpf_pkg.sv - types shared by the fuse controller modules.
// assumes gpf_params.svh for the numeric constants.
package gpf_pkg;
  typedef enum logic {GPF_IDLE, GPF_EXEC} gpf_state_e;
  typedef logic [5:0] gpf_cmd_t;
endpackage

// file: hdl/gpf_decode.sv
// gpf_decode.sv - combinational decode of the special fuses.
// assumes the fuse vector is current flip-flop state of the controller.
`include "gpf_params.svh"
`timescale 1ns/1ps
`default_nettype none
module gpf_decode #(
  parameter int FUSE_W = 32
) (
  input wire logic [FUSE_W-1:0] fuses, // current fuse values
  output logic [`GPF_N_LOCK-1:0] region_locked, // 1 = region locked
  output logic fetch_lock, // external fetch blocked
  output logic [2:0] bp_size, // boot protect code
  output logic [8:0] bp_pages, // count of protected pages
  output logic sec_state_en, // secure state enable
  output logic sec_debug_en, // secure debug enable
  output logic user_prot_en // user protection enable
);
  // the special fuses must lie inside the vector
  generate
    if (FUSE_W < `GPF_F_USER_PROT + 1) begin : g_narrow
      $error("gpf_decode: fuse vector too narrow");
    end
  endgenerate

  // erased (1) lock fuse means the region is open; see R19 R1
  genvar i;
  generate
    for (i = 0; i < `GPF_N_LOCK; i++) begin : g_lock
      assign region_locked[i] = ~fuses[i];
    end
  endgenerate

  assign fetch_lock = ~fuses[`GPF_F_FETCH_LOCK]; // see R3 R4
  assign bp_size = fuses[`GPF_F_BP_HI:`GPF_F_BP_LO];
  // 7 protects none, each lower code doubles from two pages; see R6
  assign bp_pages = (bp_size == `GPF_BP_NONE) ? 9'h000 :
    9'(9'h001 << (`GPF_BP_MAXLOG - bp_size));
  // 01 -> both on, 10 -> secure only, 00/11 -> off; see R9
  assign sec_state_en = fuses[`GPF_F_SEC_LO] ^ fuses[`GPF_F_SEC_HI];
  assign sec_debug_en = fuses[`GPF_F_SEC_LO] & ~fuses[`GPF_F_SEC_HI];
  assign user_prot_en = ~fuses[`GPF_F_USER_PROT]; // see R10
endmodule
`default_nettype wire

// file: hdl/gpf_ctrl.sv
// gpf_ctrl.sv - general-purpose fuse controller with wishbone registers.
// assumes a classic wishbone master on clk; security bit and external
// chip erase arrive as asynchronous pins.
//
// Local design decisions: the register addresses and the Wishbone slave port.
`include "gpf_params.svh"
`timescale 1ns/1ps
`default_nettype none
// Operation
// R1 - lowest 16 fuses are region lock bits, changed by lock and fuse commands
// R2 - fuse values readable at their own bus addresses
// R3 - fuse 16 erased allows external privileged fetch, programmed blocks it
// R4 - fetch lock fuse routed out raw, only protected under security bit
// R5 - no command changes fetch lock fuse while security bit set
// R6 - fuses 19:17 select boot protected size, 7 none, 0 pages 0-127
// R7 - page erase or program inside boot range refused with lock error
// R8 - boot size fuses and their pages frozen while security bit set
// R9 - fuses 21:20 decode into secure enable and secure debug enable
// R10 - fuse 22 programmed enables user protection
// R11 - single fuse write and erase act on fuse named in page field
// R12 - byte program takes index from page bits 2:0, value from 10:3
// R13 - byte program of byte 2 refused with lock error under security bit
// R14 - erase all fuses; refused with lock error under security bit
// R15 - lock error for boot, fetch lock or user protect fuse under security
// R16 - lock error for secure fuses while secure mode enabled
// R17 - wrong key or invalid command sets program error, fuses unchanged
// R18 - software writes key 0xa5; other keys start nothing
// R19 - lock fuse at 1 means unlocked, at 0 locked
// R20 - command write clears ready, completion sets it again
// R21 - program and lock error clear on status register read
// R22 - decoded outputs follow current fuse values after each operation
module gpf_ctrl #(
  parameter int FUSE_W = 32,
  parameter int PAGES = `GPF_PAGES,
  parameter int OP_CYCLES = `GPF_OP_CYCLES,
  parameter logic [FUSE_W-1:0] FUSE_INIT = '1
) (
  input wire logic clk, // 40 mhz system clock
  input wire logic nrst, // async reset, active low
  input wire logic wb_cyc_i, // wishbone cycle
  input wire logic wb_stb_i, // wishbone strobe
  input wire logic wb_we_i, // wishbone write
  input wire logic [`GPF_ADR_W-1:0] wb_adr_i, // byte address
  input wire logic [3:0] wb_sel_i, // byte selects
  input wire logic [31:0] wb_dat_i, // write data
  output logic [31:0] wb_dat_o, // read data
  output logic wb_ack_o, // one-cycle acknowledge
  input wire logic security_bit, // security bit pin, async
  input wire logic chip_erase, // external chip erase pin, async
  output logic [`GPF_N_LOCK-1:0] region_locked, // per-region lock
  output logic ext_priv_fetch_lock, // external fetch blocked
  output logic [2:0] boot_protect_size, // boot protect code
  output logic [8:0] boot_protect_pages, // protected page count
  output logic secure_state_enable, // secure state on
  output logic secure_debug_enable, // secure debug on
  output logic user_protect_enable, // user protection on
  output logic ready_flag // no command running
);
  localparam int FI_W = $clog2(FUSE_W);
  localparam int RSH = $clog2(PAGES / `GPF_N_LOCK);
  localparam int CNT_W = $clog2(OP_CYCLES + 1);

  generate
    if (FUSE_W < 24 || FUSE_W > 32 || FUSE_W % 8 != 0 || OP_CYCLES < 1 ||
        PAGES < 2 * `GPF_N_LOCK || PAGES > 65536) begin : g_bad
      $error("gpf_ctrl: unsupported parameter values");
    end
  endgenerate

  // ----------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------
  logic sec_m, sec_s, ce_m, ce_s;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sec_m <= 1'b1;
      sec_s <= 1'b1;
      ce_m <= 1'b0;
      ce_s <= 1'b0;
    end else begin
      sec_m <= security_bit;
      sec_s <= sec_m;
      ce_m <= chip_erase;
      ce_s <= ce_m;
    end
  end

  // ----------------------------------------------------------------------
  // wishbone decode
  // ----------------------------------------------------------------------
  logic req, wr_cmd, rd_stat;
  logic [7:0] key_in;
  logic [`GPF_PAGE_W-1:0] page_in;
  gpf_pkg::gpf_cmd_t cmd_in;
  // partial writes to the command word are ignored, key needs lane 3
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_cmd = req && wb_we_i && wb_adr_i == `GPF_ADR_CMD &&
    wb_sel_i == 4'hf;
  assign rd_stat = req && !wb_we_i && wb_adr_i == `GPF_ADR_STAT;
  assign key_in = wb_dat_i[`GPF_KEY_LSB +: 8];
  assign page_in = wb_dat_i[`GPF_PAGE_LSB +: `GPF_PAGE_W];
  assign cmd_in = wb_dat_i[`GPF_CMD_W-1:0];

  // ----------------------------------------------------------------------
  // command acceptance
  // ----------------------------------------------------------------------
  gpf_pkg::gpf_state_e state;
  gpf_pkg::gpf_cmd_t cmd_q;
  logic [`GPF_PAGE_W-1:0] page_q;
  logic [CNT_W-1:0] cnt;
  logic launch_ok, bad_write, done;

  // argument range check keeps indexing inside the fuse vector
  always_comb begin
    launch_ok = 1'b0;
    unique case (cmd_in)
      `GPF_C_WBIT, `GPF_C_EBIT: launch_ok = page_in < FUSE_W; // see R11
      `GPF_C_PBYTE: launch_ok = page_in[`GPF_BYTE_W-1:0] < FUSE_W / 8 &&
        page_in[`GPF_PAGE_W-1:`GPF_VAL_LSB+8] == '0;
      `GPF_C_WP, `GPF_C_EP, `GPF_C_LP, `GPF_C_UP: launch_ok = page_in < PAGES;
      `GPF_C_EALL, `GPF_C_NOP: launch_ok = 1'b1;
      default: launch_ok = 1'b0;
    endcase
  end

  // bad key, unknown code, out-of-range argument or a write while busy; see R17 R18
  assign bad_write = wr_cmd &&
    (key_in != `GPF_KEY || !launch_ok || state != gpf_pkg::GPF_IDLE);
  assign done = state == gpf_pkg::GPF_EXEC && cnt == '0;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state <= gpf_pkg::GPF_IDLE;
      cmd_q <= `GPF_C_NOP;
      page_q <= '0;
      cnt <= '0;
    end else begin
      unique case (state)
        gpf_pkg::GPF_IDLE: begin
          if (wr_cmd && !bad_write) begin
            state <= gpf_pkg::GPF_EXEC;
            cmd_q <= cmd_in;
            page_q <= page_in;
            cnt <= CNT_W'(OP_CYCLES - 1);
          end
        end
        gpf_pkg::GPF_EXEC: begin
          if (cnt == '0) begin
            state <= gpf_pkg::GPF_IDLE;
          end else begin
            cnt <= cnt - 1'b1;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // protection checks on the running command
  // ----------------------------------------------------------------------
  logic [FUSE_W-1:0] fuses;
  logic [`GPF_N_LOCK-1:0] rl_d;
  logic fl_d, sec_en_d, dbg_en_d, up_d;
  logic [2:0] bps_d;
  logic [8:0] bpp_d;
  logic [FI_W-1:0] bit_q;
  logic [`GPF_BYTE_W-1:0] byte_q;
  logic [3:0] region_q;
  logic bit_guarded, bit_secure, lerr;

  gpf_decode #(.FUSE_W(FUSE_W)) u_dec (
    .fuses(fuses),
    .region_locked(rl_d),
    .fetch_lock(fl_d),
    .bp_size(bps_d),
    .bp_pages(bpp_d),
    .sec_state_en(sec_en_d),
    .sec_debug_en(dbg_en_d),
    .user_prot_en(up_d)
  );

  assign bit_q = page_q[FI_W-1:0];
  assign byte_q = page_q[`GPF_BYTE_W-1:0];
  assign region_q = 4'(page_q >> RSH);
  // fetch lock, boot size and user protect fuses; see R5 R8 R15
  assign bit_guarded = (bit_q >= FI_W'(`GPF_F_FETCH_LOCK) &&
    bit_q <= FI_W'(`GPF_F_BP_HI)) || bit_q == FI_W'(`GPF_F_USER_PROT);
  assign bit_secure = bit_q == FI_W'(`GPF_F_SEC_LO) ||
    bit_q == FI_W'(`GPF_F_SEC_HI);

  always_comb begin
    lerr = 1'b0;
    unique case (cmd_q)
      `GPF_C_WBIT, `GPF_C_EBIT:
        lerr = (sec_s && bit_guarded) || (sec_en_d && bit_secure); // see R15 R16
      // byte 2 holds all guarded and secure fuses; see R13 R16
      `GPF_C_PBYTE: lerr = byte_q == `GPF_BYTE_SEC && (sec_s || sec_en_d);
      `GPF_C_EALL: lerr = sec_s || sec_en_d; // see R14 R16
      // boot area refused whatever the security bit; see R7 R8
      `GPF_C_WP, `GPF_C_EP:
        lerr = page_q < 16'(bpp_d) || rl_d[region_q];
      default: lerr = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------------
  // fuse storage
  // ----------------------------------------------------------------------
  // reset loads FUSE_INIT; a real array would keep its programmed values instead
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      fuses <= FUSE_INIT;
    end else if (ce_s) begin
      fuses <= '1; // external chip erase clears every lock
    end else if (done && !lerr) begin
      unique case (cmd_q)
        `GPF_C_WBIT: fuses[bit_q] <= 1'b0; // see R11
        `GPF_C_EBIT: fuses[bit_q] <= 1'b1; // see R11
        `GPF_C_PBYTE: fuses[byte_q*8 +: 8] <= page_q[`GPF_VAL_LSB +: 8]; // see R12
        `GPF_C_EALL: fuses <= '1; // see R14
        `GPF_C_LP: fuses[region_q] <= 1'b0; // see R1 R19
        `GPF_C_UP: fuses[region_q] <= 1'b1; // see R1 R19
        default: fuses <= fuses;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // status flags
  // ----------------------------------------------------------------------
  logic prog_err, lock_err;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ready_flag <= 1'b1;
    end else if (wr_cmd && !bad_write) begin
      ready_flag <= 1'b0; // see R20
    end else if (done) begin
      ready_flag <= 1'b1; // see R20
    end
  end

  // a new error beats the clear of a status read; see R21
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prog_err <= 1'b0;
    end else if (bad_write) begin
      prog_err <= 1'b1; // see R17
    end else if (rd_stat) begin
      prog_err <= 1'b0; // see R21
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lock_err <= 1'b0;
    end else if (done && lerr) begin
      lock_err <= 1'b1; // see R13 R14 R15 R16
    end else if (rd_stat) begin
      lock_err <= 1'b0; // see R21
    end
  end

  // ----------------------------------------------------------------------
  // read data and acknowledge
  // ----------------------------------------------------------------------
  logic [31:0] rdata;
  always_comb begin
    rdata = 32'h0000_0000;
    unique case (wb_adr_i)
      `GPF_ADR_CMD: begin
        rdata[`GPF_CMD_W-1:0] = cmd_q;
        rdata[`GPF_PAGE_LSB +: `GPF_PAGE_W] = page_q;
      end
      `GPF_ADR_STAT: begin
        rdata[`GPF_ST_RDY] = ready_flag;
        rdata[`GPF_ST_LOCK_ERR] = lock_err;
        rdata[`GPF_ST_PROG_ERR] = prog_err;
        rdata[`GPF_ST_SEC] = sec_s;
        rdata[`GPF_ST_LOCK_LSB +: `GPF_N_LOCK] = rl_d;
      end
      `GPF_ADR_FLO: rdata[FUSE_W-1:0] = fuses; // see R2
      default: rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req;
      wb_dat_o <= (req && !wb_we_i) ? rdata : 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------------
  // registered decode outputs
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      region_locked <= '0;
      ext_priv_fetch_lock <= 1'b0;
      boot_protect_size <= `GPF_BP_NONE;
      boot_protect_pages <= 9'h000;
      secure_state_enable <= 1'b0;
      secure_debug_enable <= 1'b0;
      user_protect_enable <= 1'b0;
    end else begin
      region_locked <= rl_d; // see R22
      ext_priv_fetch_lock <= fl_d; // see R3 R4
      boot_protect_size <= bps_d; // see R6
      boot_protect_pages <= bpp_d; // see R6
      secure_state_enable <= sec_en_d; // see R9
      secure_debug_enable <= dbg_en_d; // see R9
      user_protect_enable <= up_d; // see R10
    end
  end

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence s_launch;
    wr_cmd && !bad_write;
  endsequence
  sequence s_finish;
    !ready_flag [*2] ##[1:1000] ready_flag;
  endsequence

  ready_cycle_a: assert property (s_launch |=> s_finish) // see R20
    else $error("ready flag did not drop and return");
  bad_key_a: assert property (wr_cmd && key_in != `GPF_KEY |=> prog_err &&
    $stable(fuses) && ready_flag == $past(ready_flag)) // see R17
    else $error("bad key did not raise program error");
  stat_clear_a: assert property (rd_stat && !bad_write |=> !prog_err) // see R21
    else $error("program error survived status read");
  erase_all_lock_a: assert property (done && cmd_q == `GPF_C_EALL &&
    sec_s |=> lock_err) // see R14
    else $error("erase all under security did not lock error");
  guard_frozen_a: assert property (done && sec_s && !ce_s |=>
    $stable(fuses[`GPF_F_BP_HI:`GPF_F_FETCH_LOCK]) &&
    $stable(fuses[`GPF_F_USER_PROT])) // see R5
    else $error("guarded fuse changed under security");
  sec_decode_a: assert property (fuses[`GPF_F_SEC_HI:`GPF_F_SEC_LO] == 2'b10
    |=> secure_state_enable && !secure_debug_enable) // see R9
    else $error("secure decode wrong for code 10");
  boot_refuse_a: assert property (done && cmd_q == `GPF_C_EP &&
    page_q == 16'h0000 && bps_d != `GPF_BP_NONE |=> lock_err) // see R7
    else $error("page in boot area not refused");
  byte_prog_a: assert property (done && !lerr && !ce_s &&
    cmd_q == `GPF_C_PBYTE && byte_q == 3'h0 |=>
    fuses[7:0] == $past(page_q[10:3])) // see R12
    else $error("fuse byte not programmed");
  lock_cmd_a: assert property (done && !ce_s && cmd_q == `GPF_C_LP |=>
    ##1 region_locked[$past(region_q, 2)]) // see R1
    else $error("region lock not reflected");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
endmodule
`default_nettype wire

// file: verif/gpf_sw_model.sv
// gpf_sw_model.sv - software side of the fuse controller: a classic
// wishbone master with one blocking transfer task.
// assumes a slave that acks every request once, registered.
`timescale 1ns/1ps
`default_nettype none
module gpf_sw_model (
  input wire logic clk, // system clock
  output logic wb_cyc, // cycle
  output logic wb_stb, // strobe
  output logic wb_we, // write
  output logic [7:0] wb_adr, // byte address
  output logic [3:0] wb_sel, // byte lanes
  output logic [31:0] wb_dat, // write data
  input wire logic [31:0] wb_din, // read data
  input wire logic wb_ack // acknowledge
);
  initial begin
    wb_cyc = 1'b0;
    wb_stb = 1'b0;
    wb_we = 1'b0;
    wb_adr = 8'h00;
    wb_sel = 4'h0;
    wb_dat = 32'h00000000;
  end

  // ----------------------------------------------------------------
  // one transfer
  // ----------------------------------------------------------------
  // released lines except wb_sel show the inverse so stale values never look valid
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_adr <= a;
    wb_sel <= 4'hf;
    wb_dat <= d;
    // request stands until the rising edge that samples ack high
    do @(posedge clk); while (wb_ack !== 1'b1);
    q = wb_din;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= ~w;
    wb_adr <= ~a;
    wb_dat <= ~d;
  endtask
endmodule
`default_nettype wire

// file: verif/tb_gpf_ctrl.sv
// tb_gpf_ctrl.sv - self-checking bench for the fuse controller.
// assumes the software model as bus master and default OP_CYCLES.
`include "gpf_params.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_gpf_ctrl;
  logic clk = 1'b0, nrst = 1'b0, security_bit = 1'b0, chip_erase = 1'b0;
  logic wb_cyc, wb_stb, wb_we, wb_ack, fetch, sec_en, dbg_en, usr_prot, rdy;
  logic [7:0] wb_adr;
  logic [3:0] wb_sel;
  logic [31:0] wb_dat, wb_q, q, fz, ov;
  logic [15:0] lk;
  logic [2:0] bsz;
  logic [8:0] bpg;
  logic busy;
  int error_cnt = 0, checks = 0, cyc_cnt = 0;
  logic [31:0] bad [6];

  always #12.5 clk = ~clk;
  assign ov = {lk, fetch, bsz, bpg, sec_en, dbg_en, usr_prot};

  gpf_sw_model m (.clk(clk), .wb_cyc(wb_cyc), .wb_stb(wb_stb),
    .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat(wb_dat),
    .wb_din(wb_q), .wb_ack(wb_ack));

  gpf_ctrl dut (.clk(clk), .nrst(nrst), .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
    .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_q),
    .wb_ack_o(wb_ack), .security_bit(security_bit),
    .chip_erase(chip_erase), .region_locked(lk),
    .ext_priv_fetch_lock(fetch), .boot_protect_size(bsz),
    .boot_protect_pages(bpg), .secure_state_enable(sec_en),
    .secure_debug_enable(dbg_en), .user_protect_enable(usr_prot),
    .ready_flag(rdy));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] cmd(input logic [15:0] pg,
                                      input logic [5:0] c);
    return {`GPF_KEY, pg, 2'b00, c};
  endfunction

  function automatic logic [31:0] eo(input logic [31:0] f);
    logic [8:0] pg;
    pg = (f[19:17] == 3'h7) ? 9'h000 : 9'h001 << (3'h7 - f[19:17]);
    return {~f[15:0], ~f[16], f[19:17], pg, f[21] ^ f[20],
            ~f[21] & f[20], ~f[22]};
  endfunction

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic go(input logic [31:0] w);
    m.xfer(1'b1, `GPF_ADR_CMD, w, q);
    @(negedge clk);
    busy = rdy;
    repeat (40) if (rdy !== 1'b1) @(negedge clk);
    @(negedge clk);
    chk("ready_back", 32'h1, 32'(rdy));
  endtask

  task automatic expect_all;
    m.xfer(1'b0, `GPF_ADR_FLO, 32'h0, q);
    chk("fuse_lo", fz, q);
    chk("decoded", eo(fz), ov);
  endtask

  // refused command: flag bit b set once, cleared by the read
  task automatic refused(input logic [31:0] w, input int b);
    go(w);
    m.xfer(1'b0, `GPF_ADR_STAT, 32'h0, q);
    chk("err_flag", 32'h1, 32'(q[b]));
    m.xfer(1'b0, `GPF_ADR_STAT, 32'h0, q);
    chk("err_clear", 32'h0, 32'(q[3:2]));
  endtask

  task automatic pulse_erase;
    chip_erase <= 1'b1;
    repeat (4) @(posedge clk);
    chip_erase <= 1'b0;
    repeat (4) @(posedge clk);
    fz = '1;
  endtask

  task automatic tally_and_finish;
    if (error_cnt == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      error_cnt++;
      tally_and_finish();
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    fz = '1;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    expect_all();
    m.xfer(1'b0, `GPF_ADR_STAT, 32'h0, q);
    chk("status", 32'h00000001, q);
    m.xfer(1'b0, `GPF_ADR_FHI, 32'h0, q);
    chk("fuse_hi", 32'h0, q);
    go(cmd(16'd3, `GPF_C_WBIT));
    chk("busy", 32'h0, 32'(busy));
    fz[3] = 1'b0;
    expect_all();
    m.xfer(1'b0, `GPF_ADR_STAT, 32'h0, q);
    chk("stat_lock", 32'h0008, 32'(q[31:16]));
    go(cmd(16'd3, `GPF_C_EBIT));
    fz[3] = 1'b1;
    go(cmd(16'd16, `GPF_C_WBIT));
    fz[16] = 1'b0;
    expect_all();
    // boot size from none down to the widest range
    for (int c = 7; c >= 0; c--) begin
      go(cmd({5'h00, 1'b1, 1'b0, 2'b11, 3'(c), 1'b1, `GPF_BYTE_SEC},
             `GPF_C_PBYTE));
      fz[23:16] = {1'b1, 1'b0, 2'b11, 3'(c), 1'b1};
      expect_all();
    end
    refused(cmd(16'd127, `GPF_C_WP), `GPF_ST_LOCK_ERR);
    refused(cmd(16'd0, `GPF_C_EP), `GPF_ST_LOCK_ERR);
    go(cmd(16'd128, `GPF_C_WP));
    m.xfer(1'b0, `GPF_ADR_STAT, 32'h0, q);
    chk("boot_edge", 32'h0, 32'(q[`GPF_ST_LOCK_ERR]));
    // region 10 locked by page number, then unlocked via another page
    go(cmd(16'd160, `GPF_C_LP));
    fz[10] = 1'b0;
    expect_all();
    refused(cmd(16'd160, `GPF_C_EP), `GPF_ST_LOCK_ERR);
    go(cmd(16'd170, `GPF_C_UP));
    fz[10] = 1'b1;
    go(cmd(16'd0, `GPF_C_NOP));
    expect_all();
    go(cmd({5'h00, 8'h5a, 3'h0}, `GPF_C_PBYTE));
    fz[7:0] = 8'h5a;
    expect_all();
    // secure codes: 10 then 00, then 01 locks further changes
    go(cmd({5'h00, 8'hef, 3'h2}, `GPF_C_PBYTE));
    fz[23:16] = 8'hef;
    expect_all();
    pulse_erase();
    go(cmd({5'h00, 8'hcf, 3'h2}, `GPF_C_PBYTE));
    fz[23:16] = 8'hcf;
    expect_all();
    go(cmd({5'h00, 8'hdf, 3'h2}, `GPF_C_PBYTE));
    fz[23:16] = 8'hdf;
    expect_all();
    refused(cmd({5'h00, 8'hef, 3'h2}, `GPF_C_PBYTE), `GPF_ST_LOCK_ERR);
    refused(cmd(16'd21, `GPF_C_WBIT), `GPF_ST_LOCK_ERR);
    expect_all();
    pulse_erase();
    go(cmd(16'd16, `GPF_C_WBIT));
    fz[16] = 1'b0;
    @(posedge clk);
    security_bit <= 1'b1;
    repeat (4) @(posedge clk);
    bad = '{cmd(16'd16, `GPF_C_EBIT), cmd(16'd18, `GPF_C_WBIT),
            cmd(16'd22, `GPF_C_WBIT), cmd(16'd17, `GPF_C_EBIT),
            cmd({5'h00, 8'h00, 3'h2}, `GPF_C_PBYTE),
            cmd(16'd0, `GPF_C_EALL)};
    foreach (bad[i]) refused(bad[i], `GPF_ST_LOCK_ERR);
    go(cmd(16'd5, `GPF_C_WBIT));
    fz[5] = 1'b0;
    expect_all();
    pulse_erase();
    expect_all();
    security_bit <= 1'b0;
    repeat (4) @(posedge clk);
    go(cmd(16'd0, `GPF_C_WBIT));
    go(cmd(16'd22, `GPF_C_WBIT));
    go(cmd(16'd0, `GPF_C_EALL));
    expect_all();
    bad[0] = {8'h5a, 16'd1, 2'b00, `GPF_C_WBIT};
    bad[1] = cmd(16'd1, 6'h3f);
    for (int i = 0; i < 2; i++) refused(bad[i], `GPF_ST_PROG_ERR);
    // a second command while the first still runs is refused
    m.xfer(1'b1, `GPF_ADR_CMD, cmd(16'd1, `GPF_C_WBIT), q);
    refused(cmd(16'd2, `GPF_C_WBIT), `GPF_ST_PROG_ERR);
    fz[1] = 1'b0;
    expect_all();
    tally_and_finish();
  end
endmodule
`default_nettype wire
